// ### dv/psl_far_framer.sv
/* Far path framer model: one label per frame pulse.
   Assumes go is a one-cycle strobe on clk_sys. */
`timescale 1ns/1ps
module psl_far_framer
   import psl_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       go,
   input  wire logic       farLex,
   input  wire logic [8:0] rawLabel,
   output psl_pkg::psl_rx_s rxOut
);
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rxOut <= '0;
      end else begin
         rxOut.frameValid <= go;
         // Idle label flips so stale values never match
         if (!go) rxOut.label <= ~rxOut.label;
         else if (rawLabel[8]) rxOut.label <= rawLabel[7:0];
         else rxOut.label <= farLex ? PSL_LEX_LABEL : PSL_GFP_LABEL;
      end
   end
endmodule

// ### dv/tb_top.sv
/* Bench for the label mismatch monitor.
   Assumes the alarm answers one cycle after each frame. */
`timescale 1ns/1ps
module tb_top;
   import psl_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        go = 1'b0;
   logic        farLex = 1'b0;
   logic [8:0]  rawLabel = 9'h000;
   logic        modeLexPin = 1'b0;
   logic        linkTriggerEnPin = 1'b1;
   psl_defect_s defectIn = '0;
   psl_rx_s     rxIn;
   psl_alarm_s  alarmOut;
   int          bad_count = 0;
   int          checked = 0;
   always #20 clk_sys = ~clk_sys;
   psl_far_framer psl_far_framer_i (.clk_sys(clk_sys), .rst_b(rst_b), .go(go),
      .farLex(farLex), .rawLabel(rawLabel), .rxOut(rxIn));
   psl_mismatch_monitor psl_mismatch_monitor_i (.clk_sys(clk_sys), .rst_b(rst_b),
      .rxIn(rxIn), .defectIn(defectIn), .modeLexPin(modeLexPin),
      .linkTriggerEnPin(linkTriggerEnPin), .alarmOut(alarmOut));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic m, input logic l);
      checked++;
      if (alarmOut !== {m, l}) begin
         bad_count++;
         $display("ERROR %0t alarm %b expected %b%b", $time, alarmOut, m, l);
      end
   endtask
   task automatic frame(input logic [8:0] r, input logic m, input logic l);
      rawLabel = r;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(1);
      chk(m, l);
   endtask
   task automatic t_labels;
      farLex = 1'b1;
      frame(9'h000, 1'b1, 1'b1);
      farLex = 1'b0;
      frame(9'h000, 1'b0, 1'b0);
      frame(9'h116, 1'b0, 1'b0);
      frame(9'h101, 1'b1, 1'b1);
      frame(9'h100, 1'b0, 1'b0);
      for (int i = 0; i < 2; i++) begin
         frame(9'h101, 1'b1, 1'b1);
         frame({1'b1, (i != 0) ? 8'hFC : 8'hE1}, 1'b0, 1'b0);
      end
      modeLexPin = 1'b1;
      tick(3);
      frame(9'h1E0, 1'b1, 1'b1);
      frame(9'h1FD, 1'b1, 1'b1);
      farLex = 1'b1;
      frame(9'h000, 1'b0, 1'b0);
      $display("test labels done");
   endtask
   task automatic t_defect;
      frame(9'h11B, 1'b1, 1'b1);
      defectIn.pathPayloadLabelDefect = 1'b1;
      tick(1);
      chk(1'b0, 1'b0);
      frame(9'h11B, 1'b0, 1'b0);
      defectIn = '0;
      frame(9'h11B, 1'b1, 1'b1);
      defectIn.tributaryPayloadLabelDefect = 1'b1;
      tick(1);
      chk(1'b0, 1'b0);
      defectIn = '0;
      $display("test defect done");
   endtask
   task automatic t_trigger;
      linkTriggerEnPin = 1'b0;
      tick(3);
      frame(9'h11B, 1'b1, 1'b0);
      linkTriggerEnPin = 1'b1;
      tick(3);
      chk(1'b1, 1'b1);
      $display("test trigger done");
   endtask
   task automatic close_out;
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      tick(20);
      rst_b = 1'b1;
      tick(3);
      t_labels();
      t_defect();
      t_trigger();
      close_out();
   end
endmodule

// ### logic/psl_label_compare.sv
/*
 * Combinational label comparison for one received frame.
 * Assumes labels are stable while evaluated; no state held here.
 */
`timescale 1ns/1ps
module psl_label_compare
   import psl_pkg::*;
(
   input  wire logic [7:0] rxLabel,
   input  wire logic [7:0] expLabel,
   output logic            mismatchRaw
);
   function automatic logic isPdi(input logic [7:0] lbl);
      isPdi = (lbl >= PSL_PDI_LOW) && (lbl <= PSL_PDI_HIGH); // [R8]
   endfunction

   always_comb begin
      mismatchRaw = (rxLabel != PSL_UNEQUIPPED) // [R1]
         && !isPdi(rxLabel) // [R2]
         && (rxLabel != expLabel) // [R3]
         && ((expLabel == PSL_EQUIP_UNSPEC) || (rxLabel == PSL_EQUIP_UNSPEC)); // [R3]
   end
endmodule

// ### logic/psl_mismatch_monitor.sv
/*
 * Path signal label mismatch monitor top. Evaluates the received label
 * once per frame and drives the encapsulation mismatch alarm and the
 * link-down request.
 * Assumes rx and defect inputs come from logic on clk_sys; the mode and
 * trigger-enable inputs are static configuration pins and are synchronised.
 */
// Contract
// [R1] No alarm while received label is unequipped
// [R2] No alarm while received label is defect indication
// [R3] Alarm on differing labels involving equipped-unspecified
// [R4] Payload label defects suppress the alarm
// [R5] Alarm drops link unless trigger disabled
// [R6] GFP expects 0x1B, LAN-extension expects 0x01
// [R7] Both ends must share framing settings
// [R8] Defect range test, evaluated once per frame
`timescale 1ns/1ps
module psl_mismatch_monitor
   import psl_pkg::*;
(
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   input  wire psl_pkg::psl_rx_s     rxIn,
   input  wire psl_pkg::psl_defect_s defectIn,
   input  wire logic                 modeLexPin,
   input  wire logic                 linkTriggerEnPin,
   output psl_pkg::psl_alarm_s       alarmOut
);
   import psl_pkg::*;

   // Mode pin synchroniser
   logic       modeMeta_q;
   logic       modeSync_q;

   // Trigger-enable pin synchroniser
   logic       trigMeta_q;
   logic       trigSync_q;

   // Expected label and raw comparison
   psl_mode_e  mode;
   logic [7:0] expLabel;
   logic       mismatchRaw;

   // Frame and defect qualifiers
   logic       defectActive;
   logic       frameTake;

   // Alarm state
   logic       mismatch_d;
   logic       mismatch_q;
   logic       linkDown_d;
   logic       linkDown_q;

   // Defect indication range test, shared by the checks below
   function automatic logic inPdiRange(input logic [7:0] lbl);
      inPdiRange = (lbl >= PSL_PDI_LOW) && (lbl <= PSL_PDI_HIGH); // [R8]
   endfunction

   // Mode pin: two-stage sync, GFP out of reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         modeMeta_q <= 1'b0;
         modeSync_q <= 1'b0;
      end else begin
         modeMeta_q <= modeLexPin;
         modeSync_q <= modeMeta_q;
      end
   end

   // Trigger pin: two-stage sync, link-down enabled out of reset
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trigMeta_q <= 1'b1;
         trigSync_q <= 1'b1;
      end else begin
         trigMeta_q <= linkTriggerEnPin;
         trigSync_q <= trigMeta_q;
      end
   end

   // Expected label follows local framing; far end must match it
   always_comb begin
      mode = psl_mode_e'(modeSync_q);
      case (mode)
         PSL_MODE_GFP: expLabel = PSL_GFP_LABEL; // [R6] [R7]
         PSL_MODE_LEX: expLabel = PSL_LEX_LABEL; // [R6] [R7]
         default:      expLabel = PSL_GFP_LABEL;
      endcase
   end

   psl_label_compare u_compare (
      .rxLabel     (rxIn.label),
      .expLabel    (expLabel),
      .mismatchRaw (mismatchRaw)
   );

   // Either payload label defect outranks the encapsulation alarm
   assign defectActive = defectIn.pathPayloadLabelDefect
                         || defectIn.tributaryPayloadLabelDefect; // [R4]

   // A frame is only judged while no defect is pending
   assign frameTake = rxIn.frameValid && !defectActive; // [R8]

   // Alarm next value: cleared by defect, else re-judged per frame
   always_comb begin
      mismatch_d = mismatch_q;
      if (defectActive) begin
         mismatch_d = 1'b0; // [R4]
      end else if (frameTake) begin
         mismatch_d = mismatchRaw; // [R8]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mismatch_q <= 1'b0;
      end else begin
         mismatch_q <= mismatch_d;
      end
   end

   // Link-down follows the alarm only while the trigger is enabled
   always_comb begin
      linkDown_d = mismatch_d && trigSync_q; // [R5]
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         linkDown_q <= 1'b0;
      end else begin
         linkDown_q <= linkDown_d;
      end
   end

   assign alarmOut.mismatch = mismatch_q;
   assign alarmOut.linkDown = linkDown_q;

   unequip_quiet_a: assert property ( // [R1]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && rxIn.label == PSL_UNEQUIPPED) |=> !mismatch_q)
      else $error("alarm raised on unequipped label");

   pdi_quiet_a: assert property ( // [R2]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && inPdiRange(rxIn.label))
      |=> !mismatch_q)
      else $error("alarm raised on defect indication label");

   raise_alarm_a: assert property ( // [R3]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && !defectIn.pathPayloadLabelDefect
       && !defectIn.tributaryPayloadLabelDefect && rxIn.label != expLabel
       && rxIn.label != PSL_UNEQUIPPED
       && !inPdiRange(rxIn.label)
       && (rxIn.label == PSL_EQUIP_UNSPEC || expLabel == PSL_EQUIP_UNSPEC))
      |=> mismatch_q)
      else $error("alarm missing on label mismatch");

   match_quiet_a: assert property ( // [R3]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && rxIn.label == expLabel) |=> !mismatch_q)
      else $error("alarm raised on matching label");

   defect_demote_a: assert property ( // [R4]
      @(posedge clk_sys) disable iff (!rst_b)
      (defectIn.pathPayloadLabelDefect || defectIn.tributaryPayloadLabelDefect)
      |=> !mismatch_q && !linkDown_q)
      else $error("alarm not demoted by payload label defect");

   link_follow_a: assert property ( // [R5]
      @(posedge clk_sys) disable iff (!rst_b)
      linkDown_q == (mismatch_q && $past(trigSync_q)))
      else $error("link down does not follow alarm and enable");

   hold_between_a: assert property ( // [R8]
      @(posedge clk_sys) disable iff (!rst_b)
      (!rxIn.frameValid && !defectIn.pathPayloadLabelDefect
       && !defectIn.tributaryPayloadLabelDefect) |=> $stable(mismatch_q))
      else $error("alarm changed without a frame");

   expect_code_a: assert property ( // [R6]
      @(posedge clk_sys) disable iff (!rst_b)
      expLabel == (modeSync_q ? PSL_LEX_LABEL : PSL_GFP_LABEL))
      else $error("expected label wrong for mode");

   // Differing labels, neither equipped-unspecified: no alarm
   other_quiet_a: assert property ( // [R3]
      @(posedge clk_sys) disable iff (!rst_b)
      (frameTake && rxIn.label != expLabel
       && rxIn.label != PSL_EQUIP_UNSPEC && expLabel != PSL_EQUIP_UNSPEC)
      |=> !mismatch_q)
      else $error("alarm raised without equipped-unspecified label");

   // Report-only mode never requests link down
   report_only_a: assert property ( // [R5]
      @(posedge clk_sys) disable iff (!rst_b)
      !trigSync_q |=> !linkDown_q)
      else $error("link down while trigger disabled");

   // Enabled trigger drops the link with the alarm
   link_drop_a: assert property ( // [R5]
      @(posedge clk_sys) disable iff (!rst_b)
      (trigSync_q && mismatch_d) |=> linkDown_q)
      else $error("link not dropped on alarm");

   // Unequipped label never drops the link either
   unequip_link_a: assert property ( // [R1]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && rxIn.label == PSL_UNEQUIPPED) |=> !linkDown_q)
      else $error("link dropped on unequipped label");

   // Defect indication label never drops the link
   pdi_link_a: assert property ( // [R2]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && inPdiRange(rxIn.label)) |=> !linkDown_q)
      else $error("link dropped on defect indication label");

   // Frame ignored while a defect is pending
   defect_ignore_a: assert property ( // [R4]
      @(posedge clk_sys) disable iff (!rst_b)
      (rxIn.frameValid && defectActive) |=> !mismatch_q)
      else $error("frame judged during payload label defect");

   // Mode synchroniser passes the first stage through
   mode_sync_a: assert property ( // [R6]
      @(posedge clk_sys) disable iff (!rst_b)
      modeSync_q == $past(modeMeta_q))
      else $error("mode synchroniser out of step");

   // Trigger synchroniser passes the first stage through
   trig_sync_a: assert property ( // [R5]
      @(posedge clk_sys) disable iff (!rst_b)
      trigSync_q == $past(trigMeta_q))
      else $error("trigger synchroniser out of step");
endmodule

// ### logic/psl_pkg.sv
/*
 * Package for the path signal label mismatch monitor: label codes,
 * defect indication range and the carried structs.
 * Assumes one clock domain (clk_sys) for every user of these types.
 */
package psl_pkg;
   localparam logic [7:0] PSL_UNEQUIPPED   = 8'h00;
   localparam logic [7:0] PSL_EQUIP_UNSPEC = 8'h01;
   localparam logic [7:0] PSL_GFP_LABEL    = 8'h1B;
   localparam logic [7:0] PSL_LEX_LABEL    = 8'h01;
   localparam logic [7:0] PSL_PDI_LOW      = 8'hE1;
   localparam logic [7:0] PSL_PDI_HIGH     = 8'hFC;

   // Local framing choice, picks the expected label
   typedef enum logic [0:0] {
      PSL_MODE_GFP = 1'b0,
      PSL_MODE_LEX = 1'b1
   } psl_mode_e;

   typedef struct packed {
      logic       frameValid;
      logic [7:0] label;
   } psl_rx_s;

   typedef struct packed {
      logic pathPayloadLabelDefect;
      logic tributaryPayloadLabelDefect;
   } psl_defect_s;

   typedef struct packed {
      logic mismatch;
      logic linkDown;
   } psl_alarm_s;
endpackage
